// >>> design/piu_consts.vh
// Behaviour
// - four maskable sources plus one non-maskable
// - fixed vectors, non-maskable topmost, descending pairs
// - non-maskable preempts; maskables never preempt each other
// - pending maskables served source one first
// - global enable gates all maskable sources
// - global enable also gates wake-up
// - non-maskable latched, cleared at routine start
// - source one level or falling edge
// - source two edge, polarity selectable
// - sources three and four level only
// - edge latch held until routine starts
// - extra edges before service are lost
// - sample after each instruction, then enter
// - separate flag pairs switched on entry
// - push pc, load vector
// - maskables inhibited during routine, non-maskable active
// - return restores flag set, pops pc
// - option-clear write anomaly skips flag switch
// - or-ed events, per-event flags readable
// - option register write-only, reset zero
// - level bit six, polarity five, enable four
`ifndef PIU_CONSTS_VH
`define PIU_CONSTS_VH
`define PIU_ADDR_OPTION   12'h0C8
`define PIU_ADDR_STATUS   12'h004
`define PIU_ADDR_EVENTS   12'h008
`define PIU_ADDR_EVCLR    12'h00C
`define PIU_OPT_RESET     8'h00
`define PIU_BIT_LES       6
`define PIU_BIT_ESB       5
`define PIU_BIT_GEN       4
`define PIU_VEC_NMI       12'hFFC
`define PIU_VEC_SRC1      12'hFF6
`define PIU_VEC_SRC2      12'hFF4
`define PIU_VEC_SRC3      12'hFF2
`define PIU_VEC_SRC4      12'hFF0
`define PIU_MODE_NORMAL   2'h0
`define PIU_MODE_IRQ      2'h1
`define PIU_MODE_NMI      2'h2
`define PIU_RESP_OKAY     2'h0
`define PIU_RESP_SLVERR   2'h2
`endif

// >>> design/piu_prioritized_interrupt_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "piu_consts.vh"
module piu_prioritized_interrupt_unit #(
  parameter PC_W  = 12,
  parameter EV_W  = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [11:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [11:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              nmi_n,
  input  wire              src1_n,
  input  wire              src2_in,
  input  wire [EV_W-1:0]   src3_events,
  input  wire [EV_W-1:0]   src4_events,
  input  wire              instr_end,
  input  wire [PC_W-1:0]   pc_in,
  input  wire              return_from_interrupt_instr_exec,
  input  wire              opt_clear_early,
  input  wire              core_sleeping,
  input  wire              cpu_carry_in,
  input  wire              cpu_zero_in,
  input  wire              cpu_flags_we,
  output reg               irq_take,
  output reg  [PC_W-1:0]   pc_load,
  output reg               pc_load_valid,
  output reg               wake_req,
  output reg               carry_flag,
  output reg               zero_flag,
  output reg  [1:0]        cpu_mode
);

  reg  [7:0]      interrupt_option_register;
  reg             nmi_s1_reg;
  reg             nmi_s2_reg;
  wire            nmi_latch_reg;
  wire            src1_latch_reg;
  wire            src2_latch_reg;
  reg  [EV_W-1:0] ev3_flags_reg;
  reg  [EV_W-1:0] ev4_flags_reg;
  reg  [1:0]      mode_reg;
  reg  [1:0]      prev_mode_reg;
  reg  [PC_W-1:0] stack0_reg;
  reg  [PC_W-1:0] stack1_reg;
  reg             normal_carry_flag;
  reg             normal_zero_flag;
  reg             irq_carry_flag;
  reg             irq_zero_flag;
  reg             nmi_carry_flag;
  reg             nmi_zero_flag;
  reg             anomaly_reg;
  reg             aw_got_reg;
  reg             w_got_reg;
  reg  [11:0]     aw_addr_reg;
  reg  [31:0]     w_data_reg;
  reg  [3:0]      w_strb_reg;

  localparam [11:0] ADDR_OPTION = `PIU_ADDR_OPTION;
  localparam [11:0] ADDR_STATUS = `PIU_ADDR_STATUS;
  localparam [11:0] ADDR_EVENTS = `PIU_ADDR_EVENTS;
  localparam [11:0] ADDR_EVCLR  = `PIU_ADDR_EVCLR;

  wire global_irq_enable        = interrupt_option_register[`PIU_BIT_GEN];
  wire source2_edge_polarity    = interrupt_option_register[`PIU_BIT_ESB];
  wire source1_level_select     = interrupt_option_register[`PIU_BIT_LES];

  wire src3_req  = |src3_events;
  wire src4_req  = |src4_events;
  wire src1_req  = source1_level_select ? ~src1_n : src1_latch_reg;
  wire mask_ok   = global_irq_enable & (mode_reg == `PIU_MODE_NORMAL);
  wire take_nmi  = instr_end & nmi_latch_reg & (mode_reg != `PIU_MODE_NMI);
  wire take_s1   = instr_end & ~take_nmi & mask_ok & src1_req;
  wire take_s2   = instr_end & ~take_nmi & mask_ok & ~src1_req & src2_latch_reg;
  wire take_s3   = instr_end & ~take_nmi & mask_ok & ~src1_req & ~src2_latch_reg & src3_req;
  wire take_s4   = instr_end & ~take_nmi & mask_ok & ~src1_req & ~src2_latch_reg & ~src3_req & src4_req;
  wire take_any  = take_nmi | take_s1 | take_s2 | take_s3 | take_s4;
  wire any_req   = nmi_latch_reg | src1_req | src2_latch_reg | src3_req | src4_req;

  // edge latches hold one request until the routine starts
  piu_edge_latch #(
    .IDLE_LEVEL (1'b1)
  ) i_piu_edge_latch_nmi (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .line_in    (nmi_s2_reg),
    .rise_sel   (1'b0),
    .arm        (1'b1),
    .clear      (take_nmi),
    .latch_out  (nmi_latch_reg)
  );

  piu_edge_latch #(
    .IDLE_LEVEL (1'b1)
  ) i_piu_edge_latch_src1 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .line_in    (src1_n),
    .rise_sel   (1'b0),
    .arm        (~source1_level_select),
    .clear      (take_s1 | source1_level_select),
    .latch_out  (src1_latch_reg)
  );

  piu_edge_latch #(
    .IDLE_LEVEL (1'b0)
  ) i_piu_edge_latch_src2 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .line_in    (src2_in),
    .rise_sel   (source2_edge_polarity),
    .arm        (1'b1),
    .clear      (take_s2),
    .latch_out  (src2_latch_reg)
  );

  reg  [PC_W-1:0] vec_next;
  always @*
  begin
    vec_next = `PIU_VEC_SRC4;
    if (take_nmi)
      vec_next = `PIU_VEC_NMI;
    else if (take_s1)
      vec_next = `PIU_VEC_SRC1;
    else if (take_s2)
      vec_next = `PIU_VEC_SRC2;
    else if (take_s3)
      vec_next = `PIU_VEC_SRC3;
  end

  // axi write
  wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire wa_option = aw_addr_reg[11:2] == ADDR_OPTION[11:2];
  wire wa_evclr  = aw_addr_reg[11:2] == ADDR_EVCLR[11:2];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIU_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa_option | wa_evclr) ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
      end
    end
  end

  wire opt_we = wr_fire & wa_option & w_strb_reg[0];
  wire evc_we = wr_fire & wa_evclr & w_strb_reg[0];

  // axi read; option register is write-only and reads as zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PIU_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PIU_RESP_OKAY;
        case (s_axi_araddr[11:2])
          ADDR_OPTION[11:2]:
            s_axi_rdata <= 32'h00000000;
          ADDR_STATUS[11:2]:
            s_axi_rdata <= {24'h000000, mode_reg, src4_req, src3_req,
                            src2_latch_reg, src1_req, nmi_latch_reg, anomaly_reg};
          ADDR_EVENTS[11:2]:
            s_axi_rdata <= {16'h0000, ev4_flags_reg, ev3_flags_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PIU_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // request capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      interrupt_option_register <= `PIU_OPT_RESET;
      nmi_s1_reg     <= 1'b1;
      nmi_s2_reg     <= 1'b1;
      ev3_flags_reg  <= {EV_W{1'b0}};
      ev4_flags_reg  <= {EV_W{1'b0}};
    end
    else
    begin
      if (opt_we)
        interrupt_option_register <= {1'b0, w_data_reg[6:4], 4'h0};
      nmi_s1_reg    <= nmi_n;
      nmi_s2_reg    <= nmi_s1_reg;
      ev3_flags_reg <= (evc_we ? ev3_flags_reg & ~w_data_reg[EV_W-1:0] : ev3_flags_reg) | src3_events;
      ev4_flags_reg <= (evc_we ? ev4_flags_reg & ~w_data_reg[2*EV_W-1:EV_W] : ev4_flags_reg) | src4_events;
    end
  end

  // mode, stack and flag banks; reset starts in non-maskable mode
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg          <= `PIU_MODE_NMI;
      prev_mode_reg     <= `PIU_MODE_NORMAL;
      stack0_reg        <= {PC_W{1'b0}};
      stack1_reg        <= {PC_W{1'b0}};
      normal_carry_flag <= 1'b0;
      normal_zero_flag  <= 1'b0;
      irq_carry_flag    <= 1'b0;
      irq_zero_flag     <= 1'b0;
      nmi_carry_flag    <= 1'b0;
      nmi_zero_flag     <= 1'b0;
      anomaly_reg       <= 1'b0;
      irq_take          <= 1'b0;
      pc_load           <= {PC_W{1'b0}};
      pc_load_valid     <= 1'b0;
      wake_req          <= 1'b0;
      carry_flag        <= 1'b0;
      zero_flag         <= 1'b0;
      cpu_mode          <= `PIU_MODE_NMI;
    end
    else
    begin
      irq_take      <= take_any;
      pc_load_valid <= take_any | return_from_interrupt_instr_exec;
      wake_req      <= core_sleeping & global_irq_enable & any_req;
      if (cpu_flags_we)
      begin
        if (mode_reg == `PIU_MODE_NMI)
        begin
          nmi_carry_flag <= cpu_carry_in;
          nmi_zero_flag  <= cpu_zero_in;
        end
        else if (mode_reg == `PIU_MODE_IRQ & ~anomaly_reg)
        begin
          irq_carry_flag <= cpu_carry_in;
          irq_zero_flag  <= cpu_zero_in;
        end
        else
        begin
          normal_carry_flag <= cpu_carry_in;
          normal_zero_flag  <= cpu_zero_in;
        end
      end
      if (take_any)
      begin
        stack0_reg    <= pc_in;
        stack1_reg    <= stack0_reg;
        pc_load       <= vec_next;
        prev_mode_reg <= mode_reg;
        mode_reg      <= take_nmi ? `PIU_MODE_NMI : `PIU_MODE_IRQ;
        anomaly_reg   <= ~take_nmi & opt_clear_early;
        cpu_mode      <= take_nmi ? `PIU_MODE_NMI : `PIU_MODE_IRQ;
      end
      else if (return_from_interrupt_instr_exec)
      begin
        pc_load     <= stack0_reg;
        stack0_reg  <= stack1_reg;
        mode_reg    <= prev_mode_reg;
        cpu_mode    <= prev_mode_reg;
        prev_mode_reg <= `PIU_MODE_NORMAL;
        anomaly_reg <= 1'b0;
      end
      case (mode_reg)
        `PIU_MODE_NMI:
        begin
          carry_flag <= nmi_carry_flag;
          zero_flag  <= nmi_zero_flag;
        end
        `PIU_MODE_IRQ:
        begin
          carry_flag <= anomaly_reg ? normal_carry_flag : irq_carry_flag;
          zero_flag  <= anomaly_reg ? normal_zero_flag : irq_zero_flag;
        end
        default:
        begin
          carry_flag <= normal_carry_flag;
          zero_flag  <= normal_zero_flag;
        end
      endcase
    end
  end

endmodule // piu_prioritized_interrupt_unit

module piu_edge_latch #(
  parameter IDLE_LEVEL = 1'b1
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire line_in,
  input  wire rise_sel,
  input  wire arm,
  input  wire clear,
  output reg  latch_out
);

  reg  prev_reg;
  wire edge_seen = rise_sel ? (~prev_reg & line_in)
                            : (prev_reg & ~line_in);

  // a new edge wins over a clear in the same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_reg  <= IDLE_LEVEL;
      latch_out <= 1'b0;
    end
    else
    begin
      prev_reg <= line_in;
      if (edge_seen & arm)
        latch_out <= 1'b1;
      else if (clear)
        latch_out <= 1'b0;
    end
  end

endmodule // piu_edge_latch
`default_nettype wire

// >>> sim/piu_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "piu_consts.vh"
module piu_checker #(
  parameter PC_W = 12
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            instr_end,
  input wire logic            return_from_interrupt_instr_exec,
  input wire logic            core_sleeping,
  input wire logic            irq_take,
  input wire logic [PC_W-1:0] pc_load,
  input wire logic            pc_load_valid,
  input wire logic            wake_req,
  input wire logic [1:0]      cpu_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence entry_s;
    instr_end ##1 irq_take;
  endsequence
  take_cause_a: assert property (irq_take |-> $past(instr_end)) else $error("take off boundary");
  entry_load_a: assert property (entry_s |-> pc_load_valid) else $error("no vector load");
  nmi_vec_a: assert property (irq_take && cpu_mode == `PIU_MODE_NMI |-> pc_load == `PIU_VEC_NMI)
    else $error("bad nmi vector");
  irq_vec_a: assert property (irq_take && cpu_mode == `PIU_MODE_IRQ |->
    pc_load inside {`PIU_VEC_SRC1, `PIU_VEC_SRC2, `PIU_VEC_SRC3, `PIU_VEC_SRC4}) else $error("bad vector");
  no_preempt_a: assert property (irq_take && cpu_mode == `PIU_MODE_IRQ |-> $past(cpu_mode) == `PIU_MODE_NORMAL)
    else $error("maskable preempted");
  return_from_interrupt_instr_pop_a: assert property (return_from_interrupt_instr_exec |=> pc_load_valid && !irq_take) else $error("return no pop");
  wake_gate_a: assert property (wake_req |-> $past(core_sleeping)) else $error("wake while awake");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
endmodule // piu_checker
bind piu_prioritized_interrupt_unit piu_checker #(
  .PC_W(PC_W)
) i_piu_checker (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .instr_end     (instr_end),
  .return_from_interrupt_instr_exec     (return_from_interrupt_instr_exec),
  .core_sleeping (core_sleeping),
  .irq_take      (irq_take),
  .pc_load       (pc_load),
  .pc_load_valid (pc_load_valid),
  .wake_req      (wake_req),
  .cpu_mode      (cpu_mode)
);
`default_nettype wire

// >>> sim/piu_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module piu_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sleep,
  input  wire logic        ret_req,
  input  wire logic        pc_load_valid,
  input  wire logic [11:0] pc_load,
  output var  logic        instr_end,
  output var  logic        return_from_interrupt_instr_exec,
  output var  logic [11:0] pc_in
);
  logic [1:0] cyc;
  // one instruction every four cycles, frozen while asleep
  always @(posedge aclk)
  begin
    instr_end <= 1'b0;
    return_from_interrupt_instr_exec <= 1'b0;
    if (!aresetn)
    begin
      cyc <= 2'h0;
      pc_in <= 12'h000;
    end
    else if (pc_load_valid)
      pc_in <= pc_load;
    else if (!sleep)
    begin
      cyc <= cyc + 2'h1;
      if (cyc == 2'h3)
      begin
        pc_in <= pc_in + 12'h001;
        return_from_interrupt_instr_exec <= ret_req;
        instr_end <= !ret_req;
      end
    end
  end
endmodule // piu_core_model
`default_nettype wire

// >>> sim/test_prioritized_interrupt_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "piu_consts.vh"
module test_prioritized_interrupt_unit;
  logic        aclk, rstn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, nmi_n, s1_n, s2;
  logic        take, plv, wake, slp, ret, ie, rx;
  logic        cw, ci, zi, ocl, cf, zf;
  logic [11:0] awa, ara, pci, pcl;
  logic [31:0] wd, rdat, d;
  logic [7:0]  e3, e4;
  logic [1:0]  bresp, rresp, mode, r;
  integer      failures, total_checks, seed, n, k, pm;
  piu_prioritized_interrupt_unit i_piu_prioritized_interrupt_unit (
    .aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .nmi_n(nmi_n),
    .src1_n(s1_n), .src2_in(s2), .src3_events(e3), .src4_events(e4), .instr_end(ie), .pc_in(pci),
    .return_from_interrupt_instr_exec(rx), .opt_clear_early(ocl), .core_sleeping(slp), .cpu_carry_in(ci), .cpu_zero_in(zi),
    .cpu_flags_we(cw), .irq_take(take), .pc_load(pcl), .pc_load_valid(plv), .wake_req(wake),
    .carry_flag(cf), .zero_flag(zf), .cpu_mode(mode));
  piu_core_model i_piu_core_model (.aclk(aclk), .aresetn(rstn), .sleep(slp), .ret_req(ret),
    .pc_load_valid(plv), .pc_load(pcl), .instr_end(ie), .return_from_interrupt_instr_exec(rx), .pc_in(pci));
  task finish_test;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task ck(input logic ok, input string s);
    begin
      total_checks = total_checks + 1;
      if (ok !== 1'b1)
      begin
        $display("[FAIL] %0t %s", $time, s);
        failures = failures + 1;
      end
    end
  endtask
  task tmo;
    begin
      ck(1'b0, "timeout");
      finish_test;
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; n = 0;
      do
      begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
        n = n + 1;
      end
      while (bv !== 1'b1 && n < 40);
      r = bresp; br <= 1'b0;
      if (n >= 40) tmo;
    end
  endtask
  task rd(input [11:0] a);
    begin
      @(posedge aclk);
      ara <= a; arv <= 1'b1; rr <= 1'b1; n = 0;
      do
      begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
        n = n + 1;
      end
      while (rv !== 1'b1 && n < 40);
      d = rdat; r = rresp; rr <= 1'b0;
      if (n >= 40) tmo;
    end
  endtask
  task tk(input [11:0] v, input [1:0] m);
    begin
      n = 0;
      do
      begin
        @(posedge aclk);
        n = n + 1;
      end
      while (take !== 1'b1 && n < 80);
      if (n >= 80) tmo;
      ck(pcl === v && mode === m, "vector or mode");
    end
  endtask
  task nt;
    begin
      n = 0;
      repeat (16) @(posedge aclk) if (take !== 1'b0) n = n + 1;
      ck(n == 0, "unexpected take");
    end
  endtask
  task rt(input [1:0] m);
    begin
      @(posedge aclk);
      ret <= 1'b1; n = 0;
      do
      begin
        @(posedge aclk);
        n = n + 1;
      end
      while (rx !== 1'b1 && n < 20);
      ret <= 1'b0;
      if (n >= 20) tmo;
      repeat (2) @(posedge aclk);
      ck(mode === m, "mode after return");
    end
  endtask
  // reference: fixed priority over the pending mask
  function [11:0] pick(input integer m);
    pick = m[1] ? `PIU_VEC_SRC1 : m[2] ? `PIU_VEC_SRC2 : m[3] ? `PIU_VEC_SRC3 : `PIU_VEC_SRC4;
  endfunction
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial
  begin
    {rstn, awv, wv, br, arv, rr, ret, slp, s2, awa, ara, wd, cw, ci, zi, ocl} = '0;
    {nmi_n, s1_n, e3, e4} = 18'h30000;
    failures = 0; total_checks = 0; seed = 89309;
    repeat (12) @(posedge aclk);
    rstn <= 1'b1;
    @(posedge aclk);
    ck(mode === `PIU_MODE_NMI, "reset mode");
    rd(`PIU_ADDR_OPTION); ck(d === 32'h0 && r === `PIU_RESP_OKAY, "option read");
    wr(`PIU_ADDR_STATUS, 32'h1); ck(r === `PIU_RESP_SLVERR, "status write");
    rd(12'h010); ck(r === `PIU_RESP_SLVERR, "unmapped read");
    rt(`PIU_MODE_NORMAL);
    k = $random(seed) & 7;
    e3 <= 8'h01 << k; pm = 8;
    nt;
    rd(`PIU_ADDR_EVENTS); ck(d[7:0] === (8'h01 << k), "event flag");
    slp <= 1'b1;
    repeat (6) @(posedge aclk);
    ck(wake === 1'b0, "wake while disabled");
    wr(`PIU_ADDR_OPTION, 32'h10);
    repeat (4) @(posedge aclk);
    ck(wake === 1'b1, "wake when enabled");
    slp <= 1'b0;
    tk(pick(pm), `PIU_MODE_IRQ);
    s1_n <= 1'b0; e4 <= 8'h01 << ($random(seed) & 7); pm = pm | 18;
    nt;
    s1_n <= 1'b1;
    repeat (2) @(posedge aclk) s1_n <= ~s1_n;
    nmi_n <= 1'b0;
    tk(`PIU_VEC_NMI, `PIU_MODE_NMI);
    nmi_n <= 1'b1;
    rt(`PIU_MODE_IRQ);
    e3 <= 8'h00; pm = pm & 18;
    rt(`PIU_MODE_NORMAL);
    tk(pick(pm), `PIU_MODE_IRQ);
    pm = 16;
    rt(`PIU_MODE_NORMAL);
    tk(pick(pm), `PIU_MODE_IRQ);
    e4 <= 8'h00;
    rt(`PIU_MODE_NORMAL);
    for (k = 0; k < 2; k = k + 1)
    begin
      wr(`PIU_ADDR_OPTION, 32'h30 ^ (k << 5));
      s2 <= ~s2;
      tk(`PIU_VEC_SRC2, `PIU_MODE_IRQ);
      rt(`PIU_MODE_NORMAL);
    end
    wr(`PIU_ADDR_OPTION, 32'h50);
    s1_n <= 1'b0;
    tk(`PIU_VEC_SRC1, `PIU_MODE_IRQ);
    s1_n <= 1'b1;
    rt(`PIU_MODE_NORMAL);
    nt;
    cw <= 1'b1;
    ci <= 1'b1;
    zi <= 1'b0;
    @(posedge aclk);
    cw <= 1'b0;
    repeat (2) @(posedge aclk);
    ck(cf === 1'b1 && zf === 1'b0, "normal flags");
    s1_n <= 1'b0;
    tk(`PIU_VEC_SRC1, `PIU_MODE_IRQ);
    s1_n <= 1'b1;
    @(posedge aclk);
    ck(cf === 1'b0 && zf === 1'b0, "interrupt flags");
    rt(`PIU_MODE_NORMAL);
    ck(cf === 1'b1 && zf === 1'b0, "normal flags back");
    ocl <= 1'b1;
    s1_n <= 1'b0;
    tk(`PIU_VEC_SRC1, `PIU_MODE_IRQ);
    s1_n <= 1'b1;
    ocl <= 1'b0;
    @(posedge aclk);
    ck(cf === 1'b1, "flag pair kept");
    rd(`PIU_ADDR_STATUS);
    ck(d[7:6] === `PIU_MODE_IRQ && d[0] === 1'b1 && r === `PIU_RESP_OKAY, "status");
    rt(`PIU_MODE_NORMAL);
    wr(`PIU_ADDR_EVCLR, 32'h0000FFFF);
    ck(r === `PIU_RESP_OKAY, "event clear write");
    rd(`PIU_ADDR_EVENTS);
    ck(d[15:0] === 16'h0000, "event clear");
    finish_test;
  end
endmodule // test_prioritized_interrupt_unit
`default_nettype wire
